// ==== pel_clock_ctrl.v ====
// clock synthesizer control: staged settings, lock detect, core and aux clock enables
`timescale 1ns/1ns
`default_nettype none
`include "pel_map.vh"
module pel_clock_ctrl (
  input wire clk,
  input wire rst_b,
  input wire master_clock_pin,
  input wire [`PEL_ADDR_W-1:0] reg_addr,
  input wire [`PEL_DATA_W-1:0] reg_wdata,
  input wire reg_we,
  input wire reg_re,
  output reg [`PEL_DATA_W-1:0] reg_rdata,
  output reg core_clock_en,
  output wire synth_clock_en,
  output reg synth_locked,
  output reg aux_clock_pin_out,
  output reg aux_clock_pin_oe_b
);
  localparam integer SETTLE_CYC = `PEL_SETTLE_CYC;
  localparam [`PEL_SETTLE_W-1:0] SETTLE_LAST = SETTLE_CYC[`PEL_SETTLE_W-1:0];

  // staged registers, written by software
  reg [`PEL_FB_W-1:0] feedback_div_reg;
  reg [`PEL_DIV_W-1:0] prescale_reg;
  reg core_source_reg;
  reg run_bit;
  reg [`PEL_AUX_W-1:0] aux_reg;

  // applied settings, loaded on run rising edge
  reg [`PEL_FB_W-1:0] synth_feedback_div;
  reg [`PEL_DIV_W-1:0] act_prescale;
  reg core_source_sel;
  reg aux_clock_drive;
  reg [`PEL_DIV_W-1:0] aux_clock_rate;
  reg run_prev;
  wire run_rise;

  // input path
  wire master_level;
  wire master_tick;
  reg [`PEL_PRE_W-1:0] pre_cnt;
  reg [`PEL_PRE_W-1:0] pre_last;
  reg prescale_tick;

  // period measurement and lock
  reg [`PEL_PER_W-1:0] per_cnt;
  reg [`PEL_PER_W-1:0] per_last;
  wire [`PEL_PER_W-1:0] per_new;
  wire [`PEL_PER_W-1:0] per_diff;
  wire per_close;
  reg [`PEL_STB_W-1:0] stable_cnt;
  wire input_stable;
  wire cfg_ok;
  wire lock_cond;
  reg [`PEL_SETTLE_W-1:0] settle_cnt;
  wire next_locked;

  // generators
  wire synth_run;
  wire aux_run;
  wire aux_pulse;
  reg [`PEL_INC_W-1:0] aux_step;
  wire [`PEL_INC_W-1:0] synth_step;

  // write decode
  wire wr_feedback;
  wire wr_prescale;
  wire wr_source;
  wire wr_run;
  wire wr_aux;
  assign wr_feedback = reg_we && (reg_addr == `PEL_OFS_FEEDBACK);
  assign wr_prescale = reg_we && (reg_addr == `PEL_OFS_PRESCALE);
  assign wr_source = reg_we && (reg_addr == `PEL_OFS_SOURCE);
  assign wr_run = reg_we && (reg_addr == `PEL_OFS_RUN);
  assign wr_aux = reg_we && (reg_addr == `PEL_OFS_AUX);

  // staged register file
  always @(posedge clk) begin
    if (!rst_b) begin
      feedback_div_reg <= `PEL_FB_RESET;
      prescale_reg <= `PEL_DIV_RESET;
      core_source_reg <= `PEL_SRC_RESET;
      run_bit <= `PEL_RUN_RESET;
      aux_reg <= `PEL_AUX_RESET;
    end else begin
      if (wr_feedback) begin
        feedback_div_reg <= reg_wdata[`PEL_FB_W-1:0];
      end
      if (wr_prescale) begin
        prescale_reg <= reg_wdata[`PEL_DIV_W-1:0];
      end
      if (wr_source) begin
        core_source_reg <= reg_wdata[`PEL_BIT_SRC];
      end
      if (wr_run) begin
        run_bit <= reg_wdata[`PEL_BIT_RUN];
      end
      if (wr_aux) begin
        aux_reg <= reg_wdata[`PEL_AUX_W-1:0];
      end
    end
  end

  // staged values become active only on the run rising edge
  assign run_rise = run_bit & ~run_prev;
  always @(posedge clk) begin
    if (!rst_b) begin
      run_prev <= `PEL_RUN_RESET;
      synth_feedback_div <= `PEL_FB_RESET;
      act_prescale <= `PEL_DIV_RESET;
      core_source_sel <= `PEL_SRC_RESET;
      aux_clock_drive <= 1'b0;
      aux_clock_rate <= `PEL_RATE_X1;
    end else begin
      run_prev <= run_bit;
      if (run_rise) begin
        synth_feedback_div <= feedback_div_reg;
        act_prescale <= prescale_reg;
        core_source_sel <= core_source_reg;
        aux_clock_drive <= aux_reg[`PEL_BIT_DRIVE];
        aux_clock_rate <= aux_reg[`PEL_RATE_HI:`PEL_RATE_LO];
      end
    end
  end

  pel_pin_sync u_master_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(master_clock_pin),
    .level(master_level),
    .rise(master_tick)
  );

  // prescale divider terminal count
  always @* begin
    case (act_prescale)
      `PEL_DIV_BY1: pre_last = `PEL_PRE_LAST1;
      `PEL_DIV_BY2: pre_last = `PEL_PRE_LAST2;
      `PEL_DIV_BY4: pre_last = `PEL_PRE_LAST4;
      `PEL_DIV_BY8: pre_last = `PEL_PRE_LAST8;
      default: pre_last = `PEL_PRE_LAST1;
    endcase
  end

  // prescaler held idle while not running
  always @(posedge clk) begin
    if (!rst_b) begin
      pre_cnt <= {`PEL_PRE_W{1'b0}};
      prescale_tick <= 1'b0;
    end else if (!run_bit) begin
      pre_cnt <= {`PEL_PRE_W{1'b0}};
      prescale_tick <= 1'b0;
    end else if (master_tick) begin
      if (pre_cnt >= pre_last) begin
        pre_cnt <= {`PEL_PRE_W{1'b0}};
        prescale_tick <= 1'b1;
      end else begin
        pre_cnt <= pre_cnt + {{(`PEL_PRE_W-1){1'b0}}, 1'b1};
        prescale_tick <= 1'b0;
      end
    end else begin
      prescale_tick <= 1'b0;
    end
  end

  // input period in clk cycles and its stability
  assign per_new = per_cnt + `PEL_PER_ONE;
  assign per_diff = (per_new > per_last) ? (per_new - per_last) : (per_last - per_new);
  assign per_close = (per_last != `PEL_PER_ZERO) && (per_diff <= `PEL_PER_TOL);
  always @(posedge clk) begin
    if (!rst_b) begin
      per_cnt <= `PEL_PER_ZERO;
      per_last <= `PEL_PER_ZERO;
      stable_cnt <= {`PEL_STB_W{1'b0}};
    end else if (!run_bit) begin
      per_cnt <= `PEL_PER_ZERO;
      per_last <= `PEL_PER_ZERO;
      stable_cnt <= {`PEL_STB_W{1'b0}};
    end else if (prescale_tick) begin
      per_cnt <= `PEL_PER_ZERO;
      per_last <= per_new;
      if (!per_close) begin
        stable_cnt <= {`PEL_STB_W{1'b0}};
      end else if (stable_cnt != `PEL_STABLE_TICKS) begin
        stable_cnt <= stable_cnt + {{(`PEL_STB_W-1){1'b0}}, 1'b1};
      end
    end else if (per_cnt == `PEL_PER_MAX) begin
      // input clock lost
      per_cnt <= `PEL_PER_ZERO;
      per_last <= `PEL_PER_ZERO;
      stable_cnt <= {`PEL_STB_W{1'b0}};
    end else begin
      per_cnt <= per_new;
    end
  end

  // lock qualification and settle timer
  assign input_stable = (stable_cnt == `PEL_STABLE_TICKS);
  assign cfg_ok = (synth_feedback_div != `PEL_FB_ZERO);
  assign lock_cond = run_bit && input_stable && cfg_ok;
  always @(posedge clk) begin
    if (!rst_b) begin
      settle_cnt <= {`PEL_SETTLE_W{1'b0}};
    end else if (!lock_cond) begin
      settle_cnt <= {`PEL_SETTLE_W{1'b0}};
    end else if (settle_cnt != SETTLE_LAST) begin
      settle_cnt <= settle_cnt + {{(`PEL_SETTLE_W-1){1'b0}}, 1'b1};
    end
  end
  assign next_locked = lock_cond && (settle_cnt == SETTLE_LAST);
  always @(posedge clk) begin
    if (!rst_b) begin
      synth_locked <= `PEL_LOCK_RESET;
    end else begin
      synth_locked <= next_locked;
    end
  end

  // synthesized clock: feedback divider times the prescaled input
  assign synth_run = run_bit && (per_last != `PEL_PER_ZERO);
  assign synth_step = {{(`PEL_INC_W-`PEL_FB_W){1'b0}}, synth_feedback_div};
  pel_rate_gen u_synth_gen (
    .clk(clk),
    .rst_b(rst_b),
    .run(synth_run),
    .step(synth_step),
    .modulus(per_last),
    .pulse(synth_clock_en)
  );

  // core clock source mux
  always @(posedge clk) begin
    if (!rst_b) begin
      core_clock_en <= 1'b0;
    end else if (core_source_sel == `PEL_SRC_PIN) begin
      core_clock_en <= master_tick;
    end else begin
      core_clock_en <= synth_clock_en;
    end
  end

  // aux clock: two toggles per output period, relative to prescaler rate
  always @* begin
    case (aux_clock_rate)
      `PEL_RATE_X1: aux_step = `PEL_AUX_STEP_X1;
      `PEL_RATE_X2: aux_step = `PEL_AUX_STEP_X2;
      `PEL_RATE_X4: aux_step = `PEL_AUX_STEP_X4;
      `PEL_RATE_X8: aux_step = `PEL_AUX_STEP_X8;
      default: aux_step = `PEL_AUX_STEP_X1;
    endcase
  end
  // measured period tracks the input family
  assign aux_run = run_bit && aux_clock_drive && (per_last != `PEL_PER_ZERO);
  pel_rate_gen u_aux_gen (
    .clk(clk),
    .rst_b(rst_b),
    .run(aux_run),
    .step(aux_step),
    .modulus(per_last),
    .pulse(aux_pulse)
  );
  always @(posedge clk) begin
    if (!rst_b) begin
      aux_clock_pin_out <= 1'b0;
      aux_clock_pin_oe_b <= 1'b1;
    end else begin
      aux_clock_pin_oe_b <= ~aux_clock_drive;
      if (!aux_run) begin
        aux_clock_pin_out <= 1'b0;
      end else if (aux_pulse) begin
        aux_clock_pin_out <= ~aux_clock_pin_out;
      end
    end
  end

  // read port, data valid in the cycle after the strobe only
  always @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= {`PEL_DATA_W{1'b0}};
    end else if (reg_re) begin
      case (reg_addr)
        `PEL_OFS_FEEDBACK: reg_rdata <= {{(`PEL_DATA_W-`PEL_FB_W){1'b0}}, feedback_div_reg};
        `PEL_OFS_PRESCALE: reg_rdata <= {{(`PEL_DATA_W-`PEL_DIV_W){1'b0}}, prescale_reg};
        `PEL_OFS_SOURCE: reg_rdata <= {{(`PEL_DATA_W-1){1'b0}}, core_source_reg};
        `PEL_OFS_RUN: reg_rdata <= {{(`PEL_DATA_W-1){1'b0}}, run_bit};
        `PEL_OFS_LOCK: reg_rdata <= {{(`PEL_DATA_W-1){1'b0}}, synth_locked};
        `PEL_OFS_AUX: reg_rdata <= {{(`PEL_DATA_W-`PEL_AUX_W){1'b0}}, aux_reg};
        default: reg_rdata <= {`PEL_DATA_W{1'b0}};
      endcase
    end else begin
      reg_rdata <= {`PEL_DATA_W{1'b0}};
    end
  end
endmodule // pel_clock_ctrl
`default_nettype wire

// ==== pel_clock_ctrl_props.sv ====
// checker for the clock synthesizer control ports
`timescale 1ns/1ns
`default_nettype none
`include "pel_map.vh"
module pel_clock_ctrl_chk (
  input wire clk,
  input wire rst_b,
  input wire master_clock_pin,
  input wire [`PEL_ADDR_W-1:0] reg_addr,
  input wire [`PEL_DATA_W-1:0] reg_wdata,
  input wire reg_we,
  input wire reg_re,
  input wire [`PEL_DATA_W-1:0] reg_rdata,
  input wire core_clock_en,
  input wire synth_clock_en,
  input wire synth_locked,
  input wire aux_clock_pin_out,
  input wire aux_clock_pin_oe_b
);
  logic run, run_d, st_src, st_drv, src, drv;
  logic [11:0] run_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // shadow of run bit and applied settings
  always @(posedge clk) begin
    if (!rst_b) begin
      run <= 1'b0;
      run_d <= 1'b0;
      st_src <= 1'b0;
      st_drv <= 1'b0;
      src <= 1'b0;
      drv <= 1'b0;
      run_cnt <= 12'h000;
    end else begin
      if (reg_we && reg_addr == `PEL_OFS_RUN) run <= reg_wdata[0];
      if (reg_we && reg_addr == `PEL_OFS_SOURCE) st_src <= reg_wdata[0];
      if (reg_we && reg_addr == `PEL_OFS_AUX) st_drv <= reg_wdata[0];
      run_d <= run;
      if (run && !run_d) begin
        src <= st_src;
        drv <= st_drv;
      end
      run_cnt <= !run ? 12'h000 : run_cnt + {11'h000, run_cnt != 12'hfff};
    end
  end
  sequence s_idle;
    !run [*4];
  endsequence
  sequence s_src_synth;
    src [*3] ##0 core_clock_en;
  endsequence
  sequence s_src_pin;
    !src [*3] ##0 core_clock_en;
  endsequence
  sequence s_lock_rd;
    reg_re && reg_addr == `PEL_OFS_LOCK;
  endsequence
  a_rdata_idle: assert property (!reg_re |=> reg_rdata == 16'h0000) else $error("read data not idle");
  a_lock_read: assert property (s_lock_rd |=> reg_rdata == {15'h0000, $past(synth_locked)})
    else $error("lock readback wrong");
  a_synth_idle: assert property (s_idle |-> !synth_clock_en) else $error("synth clock while stopped");
  a_aux_idle: assert property (s_idle |-> !aux_clock_pin_out) else $error("aux clock while stopped");
  a_lock_drop: assert property (!run [*2] |-> !synth_locked) else $error("lock while stopped");
  a_lock_settle: assert property ($rose(synth_locked) |-> run_cnt > 12'h9c4) else $error("lock too early");
  a_drive_on: assert property (drv [*3] |-> !aux_clock_pin_oe_b) else $error("aux pin not driven");
  a_drive_off: assert property (!drv [*3] |-> aux_clock_pin_oe_b) else $error("aux pin not released");
  a_core_synth: assert property (s_src_synth |-> $past(synth_clock_en)) else $error("core not from synth");
  a_core_pin: assert property (s_src_pin |=> !core_clock_en) else $error("core not from pin");
endmodule // pel_clock_ctrl_chk
bind pel_clock_ctrl pel_clock_ctrl_chk chk (.clk, .rst_b, .master_clock_pin, .reg_addr, .reg_wdata, .reg_we,
  .reg_re, .reg_rdata, .core_clock_en, .synth_clock_en, .synth_locked, .aux_clock_pin_out, .aux_clock_pin_oe_b);
`default_nettype wire

// ==== pel_map.vh ====
// register map, field layout and timing constants for the clock synthesizer control
// Operation
// - bit 0 of source register: 0 routes master pin to core, 1 the synthesizer
// - synthesizer never tries to lock while the run bit is cleared
// - run bit cleared means no synthesizer clock, dependent clocks go idle
// - staged divider, source and aux settings take effect only on run rising edge
// - read-only lock flag in bit 0 of the lock register, resets to zero
// - lock needs stable input, sane dividers, run bit set and settle time passed
// - aux rate field bits 2:1, code 00 gives the prescaler output rate
// - aux rates scale with whatever input clock family feeds the prescaler
// - aux rate codes 01, 10, 11 give two, four, eight times prescaler rate
// - aux drive bit 0 drives the aux pin, cleared leaves it high impedance
// - staged feedback divider is seven bits, multiplies input, resets to 0x60
// - staged prescale code divides master clock by 1, 2, 4 or 8
`ifndef PEL_MAP_VH
`define PEL_MAP_VH
`define PEL_ADDR_W 16
`define PEL_DATA_W 16
`define PEL_OFS_FEEDBACK 16'hf000
`define PEL_OFS_PRESCALE 16'hf001
`define PEL_OFS_SOURCE 16'hf002
`define PEL_OFS_RUN 16'hf003
`define PEL_OFS_LOCK 16'hf004
`define PEL_OFS_AUX 16'hf005
`define PEL_FB_W 7
`define PEL_FB_RESET 7'h60
`define PEL_FB_ZERO 7'h00
`define PEL_DIV_W 2
`define PEL_DIV_RESET 2'h0
`define PEL_DIV_BY1 2'h0
`define PEL_DIV_BY2 2'h1
`define PEL_DIV_BY4 2'h2
`define PEL_DIV_BY8 2'h3
`define PEL_PRE_W 3
`define PEL_PRE_LAST1 3'h0
`define PEL_PRE_LAST2 3'h1
`define PEL_PRE_LAST4 3'h3
`define PEL_PRE_LAST8 3'h7
`define PEL_SRC_RESET 1'h0
`define PEL_SRC_PIN 1'h0
`define PEL_RUN_RESET 1'h0
`define PEL_LOCK_RESET 1'h0
`define PEL_AUX_W 3
`define PEL_AUX_RESET 3'h0
`define PEL_BIT_RUN 0
`define PEL_BIT_SRC 0
`define PEL_BIT_DRIVE 0
`define PEL_RATE_HI 2
`define PEL_RATE_LO 1
`define PEL_RATE_X1 2'h0
`define PEL_RATE_X2 2'h1
`define PEL_RATE_X4 2'h2
`define PEL_RATE_X8 2'h3
`define PEL_INC_W 11
`define PEL_AUX_STEP_X1 11'h002
`define PEL_AUX_STEP_X2 11'h004
`define PEL_AUX_STEP_X4 11'h008
`define PEL_AUX_STEP_X8 11'h010
`define PEL_PER_W 16
`define PEL_PER_ZERO 16'h0000
`define PEL_PER_ONE 16'h0001
`define PEL_PER_MAX 16'hffff
`define PEL_PER_TOL 16'h0002
`define PEL_ACC_W 17
`define PEL_STB_W 4
`define PEL_STABLE_TICKS 4'h8
`define PEL_CLK_PERIOD_NS 8
`define PEL_SETTLE_NS 20000
`define PEL_SETTLE_CYC ((`PEL_SETTLE_NS + `PEL_CLK_PERIOD_NS - 1) / `PEL_CLK_PERIOD_NS)
`define PEL_SETTLE_W 12
`endif

// ==== pel_mclk_src.sv ====
// free running master clock source for the clock pin
`timescale 1ns/1ns
`default_nettype none
module pel_mclk_src (
  input wire logic [7:0] period_cyc,
  output logic master_clock_pin
);
  // stable input clock, period in core cycles, phase unrelated to core clock
  initial begin
    master_clock_pin = 1'b0;
    #3;
    forever #(period_cyc * 4) master_clock_pin = ~master_clock_pin;
  end
endmodule // pel_mclk_src
`default_nettype wire

// ==== pel_pin_sync.v ====
// two-flop pin synchronizer with rising edge pulse
`timescale 1ns/1ns
`default_nettype none
module pel_pin_sync (
  input wire clk,
  input wire rst_b,
  input wire pin,
  output wire level,
  output wire rise
);
  reg stage1;
  reg stage2;
  reg stage3;
  always @(posedge clk) begin
    if (!rst_b) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end
  assign level = stage2;
  assign rise = stage2 & ~stage3;
endmodule // pel_pin_sync
`default_nettype wire

// ==== pel_rate_gen.v ====
// phase accumulator making step pulses per modulus clock cycles
`timescale 1ns/1ns
`default_nettype none
`include "pel_map.vh"
module pel_rate_gen (
  input wire clk,
  input wire rst_b,
  input wire run,
  input wire [`PEL_INC_W-1:0] step,
  input wire [`PEL_PER_W-1:0] modulus,
  output reg pulse
);
  reg [`PEL_ACC_W-1:0] acc;
  wire [`PEL_ACC_W-1:0] step_w;
  wire [`PEL_ACC_W-1:0] mod_w;
  wire [`PEL_ACC_W-1:0] sum;
  wire [`PEL_ACC_W-1:0] diff;
  assign step_w = {{(`PEL_ACC_W-`PEL_INC_W){1'b0}}, step};
  assign mod_w = {{(`PEL_ACC_W-`PEL_PER_W){1'b0}}, modulus};
  assign sum = acc + step_w;
  assign diff = sum - mod_w;
  always @(posedge clk) begin
    if (!rst_b) begin
      acc <= {`PEL_ACC_W{1'b0}};
      pulse <= 1'b0;
    end else if (!run || modulus == `PEL_PER_ZERO) begin
      acc <= {`PEL_ACC_W{1'b0}};
      pulse <= 1'b0;
    end else if (sum >= mod_w) begin
      // rate above clk saturates at one pulse per cycle
      acc <= (diff >= mod_w) ? {`PEL_ACC_W{1'b0}} : diff;
      pulse <= 1'b1;
    end else begin
      acc <= sum;
      pulse <= 1'b0;
    end
  end
endmodule // pel_rate_gen
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the clock synthesizer control
`timescale 1ns/1ns
`default_nettype none
`include "pel_map.vh"
module tb;
  logic clk = 1'b0, rst_b = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, rd;
  logic [7:0] per = 8'h28;
  wire master_clock_pin, core_clock_en, synth_clock_en, synth_locked, aux_clock_pin_out, aux_clock_pin_oe_b;
  wire [15:0] reg_rdata;
  int errors = 0, samples_checked = 0, cyc = 0, i, t, tog, cor, e;
  logic [47:0] rows [0:6] = '{48'hf000_ffff_007f, 48'hf001_ffff_0003, 48'hf002_ffff_0001, 48'hf005_ffff_0007,
    48'hf004_ffff_0000, 48'hf0ff_ffff_0000, 48'hf003_fffe_0000};
  // master period, prescale code, rate code
  logic [15:0] rt [0:5] = '{16'h2800, 16'h2801, 16'h1412, 16'h0a23, 16'h2c01, 16'h0533};
  always #4 clk = ~clk;
  pel_mclk_src mclk (.period_cyc(per), .master_clock_pin(master_clock_pin));
  pel_clock_ctrl dut (.clk, .rst_b, .master_clock_pin, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
    .core_clock_en, .synth_clock_en, .synth_locked, .aux_clock_pin_out, .aux_clock_pin_oe_b);
  task automatic results;
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
    samples_checked++;
    if (g !== x) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic ok(input string nm, input logic c);
    chk(nm, 16'h0001, {15'h0000, c});
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdr(input logic [15:0] a);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 rd = reg_rdata;
    @(posedge clk);
  endtask
  task automatic count(input int k);
    logic last;
    tog = 0;
    cor = 0;
    last = aux_clock_pin_out;
    repeat (k) begin
      @(posedge clk);
      #1;
      tog += (aux_clock_pin_out !== last);
      cor += (core_clock_en === 1'b1);
      last = aux_clock_pin_out;
    end
    @(posedge clk);
  endtask
  task automatic lock_wait;
    t = 0;
    while (synth_locked !== 1'b1 && t < 6000) begin
      @(posedge clk);
      t++;
    end
  endtask
  task automatic reset;
    rst_b <= 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask
  initial begin
    reset();
    for (i = 0; i < 6; i++) begin
      rdr(16'hf000 + 16'(i));
      chk("reset value", i == 0 ? 16'h0060 : 16'h0000, rd);
    end
    ok("oe after reset", aux_clock_pin_oe_b === 1'b1);
    repeat (3000) @(posedge clk);
    ok("no lock when stopped", synth_locked === 1'b0);
    for (i = 0; i < 7; i++) begin
      wr(rows[i][47:32], rows[i][31:16]);
      rdr(rows[i][47:32]);
      chk("readback", rows[i][15:0], rd);
    end
    for (i = 0; i < 6; i++) begin
      per <= rt[i][15:8];
      wr(`PEL_OFS_FEEDBACK, 16'h0060);
      wr(`PEL_OFS_PRESCALE, {12'h000, rt[i][7:4]});
      wr(`PEL_OFS_SOURCE, 16'h0001);
      wr(`PEL_OFS_AUX, {13'h0000, rt[i][1:0], 1'b1});
      wr(`PEL_OFS_RUN, 16'h0001);
      lock_wait();
      ok("lock", synth_locked === 1'b1);
      ok("lock time", t > 2500);
      count(440);
      e = 880 * (1 << rt[i][3:0]) / (int'(rt[i][15:8]) << rt[i][7:4]);
      ok("aux rate", tog >= e - 4 && tog <= e + 4);
      ok("core from synth", cor > 430);
      wr(`PEL_OFS_RUN, 16'h0000);
    end
    wr(`PEL_OFS_RUN, 16'h0001);
    lock_wait();
    wr(`PEL_OFS_AUX, 16'h0000);
    repeat (4) @(posedge clk);
    ok("aux held while running", aux_clock_pin_oe_b === 1'b0);
    wr(`PEL_OFS_RUN, 16'h0000);
    @(posedge clk);
    ok("lock drop", synth_locked === 1'b0);
    count(50);
    ok("no clocks stopped", tog == 0 && cor == 0);
    ok("synth idle", synth_clock_en === 1'b0);
    wr(`PEL_OFS_RUN, 16'h0001);
    repeat (3) @(posedge clk);
    ok("aux released", aux_clock_pin_oe_b === 1'b1);
    wr(`PEL_OFS_RUN, 16'h0000);
    wr(`PEL_OFS_FEEDBACK, 16'h0000);
    wr(`PEL_OFS_RUN, 16'h0001);
    repeat (3500) @(posedge clk);
    ok("no lock zero divider", synth_locked === 1'b0);
    wr(`PEL_OFS_RUN, 16'h0000);
    per <= 8'h28;
    wr(`PEL_OFS_FEEDBACK, 16'h0060);
    wr(`PEL_OFS_SOURCE, 16'h0000);
    wr(`PEL_OFS_RUN, 16'h0001);
    repeat (50) @(posedge clk);
    count(440);
    ok("core from pin", cor >= 10 && cor <= 12);
    reset();
    ok("lock after reset", synth_locked === 1'b0);
    rdr(`PEL_OFS_FEEDBACK);
    chk("feedback after reset", 16'h0060, rd);
    results();
  end
endmodule // tb
`default_nettype wire
